// *** shared/iema_pkg.sv ***
// constants, codes and types of the two-wire eeprom master
// assumes a 25 MHz system clock and a 400 kHz transfer clock
package iema_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int XFER_HZ = 400_000;
   // quarter of a transfer clock period, rounded up
   localparam int QTR_CYC = (CLK_HZ + 4 * XFER_HZ - 1) / (4 * XFER_HZ);
   localparam int XFER_CYC = 4 * QTR_CYC;
   // flag wait minimums in transfer clock periods, plus a margin factor
   localparam int BUSY_MIN_PER = 2;
   localparam int STOP_MIN_PER = 2;
   localparam int ACK_MIN_PER = 21;
   localparam int TMO_MARGIN = 4;
   localparam int TMO_SHORT_CYC = BUSY_MIN_PER * TMO_MARGIN * XFER_CYC;
   localparam int TMO_LONG_CYC = ACK_MIN_PER * TMO_MARGIN * XFER_CYC;
   localparam int POLL_LIMIT = 255;
   // slave address byte fields, ack levels, single-byte length and pin drive level
   localparam logic [3:0] DEV_CODE = 4'ha;
   localparam logic [2:0] DEV_SEL = 3'h0;
   localparam logic DIR_WR = 1'b0;
   localparam logic DIR_RD = 1'b1;
   localparam logic ACK_VAL = 1'b0;
   localparam logic NACK_VAL = 1'b1;
   localparam logic [7:0] LEN_ONE = 8'h01;
   localparam logic PIN_LOW = 1'b0;

   typedef enum logic [1:0] {OP_RD_RANDOM, OP_RD_SEQ, OP_WR_BYTE,
      OP_WR_PAGE} iema_op_e;
   typedef enum logic [1:0] {ERR_NONE, ERR_NACK, ERR_TIMEOUT} iema_err_e;
   typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ,
      CMD_STOP} iema_cmd_e;
endpackage : iema_pkg

// *** shared/iema_eng_if.sv ***
// link between the transfer sequencer and the bit engine
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface iema_eng_if;
   import iema_pkg::*;
   iema_cmd_e cmd;
   logic cmd_valid;
   logic [7:0] tx_byte;
   logic ack_send;
   logic abort;
   logic scl_hi;
   logic sda_hi;
   logic done;
   logic ack_rx;
   logic [7:0] rx_byte;
   logic scl_oe_n;
   logic sda_oe_n;
   modport ctl (output cmd, cmd_valid, tx_byte, ack_send, abort, scl_hi,
      sda_hi, input done, ack_rx, rx_byte, scl_oe_n, sda_oe_n);
   modport eng (input cmd, cmd_valid, tx_byte, ack_send, abort, scl_hi,
      sda_hi, output done, ack_rx, rx_byte, scl_oe_n, sda_oe_n);
endinterface : iema_eng_if
`default_nettype wire

// *** logic/iema_bit_engine.sv ***
// bit engine: start, stop, byte write and byte read on the two wires
// assumes synchronised pin levels and one command at a time while idle
`timescale 1ns/10ps
`default_nettype none
module iema_bit_engine (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   iema_eng_if.eng eng
);
   import iema_pkg::*;
   typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} iema_est_e;
   iema_est_e st, next_st;
   logic [4:0] tick_cnt, next_tick_cnt;
   logic [1:0] q, next_q;
   logic [3:0] bitn, next_bitn;
   logic [7:0] sh, next_sh;
   logic is_rd, next_is_rd, ackv, next_ackv;
   logic scl_oe_n, next_scl_oe_n, sda_oe_n, next_sda_oe_n;
   logic done, next_done, ack_rx, next_ack_rx;
   logic stretch, tick;

   // high phase waits until the wire really is high (clock stretching)
   assign stretch = (st != E_IDLE) && (q == 2'h2) && !eng.scl_hi;
   assign tick = (tick_cnt == 5'(QTR_CYC - 1)) && !stretch;

   // quarter-period sequencing of every bus condition
   always_comb begin
      next_st = st;
      next_tick_cnt = tick_cnt;
      next_q = q;
      next_bitn = bitn;
      next_sh = sh;
      next_is_rd = is_rd;
      next_ackv = ackv;
      next_scl_oe_n = scl_oe_n;
      next_sda_oe_n = sda_oe_n;
      next_done = 1'b0;
      next_ack_rx = ack_rx;
      if (eng.abort) begin
         next_st = E_IDLE;
         next_scl_oe_n = 1'b1;
         next_sda_oe_n = 1'b1;
      end else if (st == E_IDLE) begin
         next_tick_cnt = 5'h00;
         next_q = 2'h0;
         next_bitn = 4'h0;
         if (eng.cmd_valid) begin
            next_sh = eng.tx_byte;
            next_is_rd = (eng.cmd == CMD_READ);
            next_ackv = eng.ack_send;
            unique case (eng.cmd)
               CMD_START: next_st = E_START;
               CMD_STOP: next_st = E_STOP;
               CMD_WRITE, CMD_READ: next_st = E_BIT;
            endcase
         end
      end else begin
         if (tick) begin
            next_tick_cnt = 5'h00;
            next_q = q + 2'h1;
         end else if (!stretch) begin
            next_tick_cnt = tick_cnt + 5'h01;
         end
         if (tick) begin
            unique case (st)
               E_START: begin
                  unique case (q)
                     2'h0: next_sda_oe_n = 1'b1;
                     2'h1: next_scl_oe_n = 1'b1;
                     2'h2: next_sda_oe_n = 1'b0;
                     2'h3: begin
                        next_scl_oe_n = 1'b0;
                        next_done = 1'b1;
                        next_st = E_IDLE;
                     end
                  endcase
               end
               E_BIT: begin
                  unique case (q)
                     // RQ18 ack value driven
                     2'h0: begin
                        if (bitn == 4'h8) begin
                           next_sda_oe_n = is_rd ? ackv : 1'b1;
                        end else begin
                           next_sda_oe_n = is_rd | sh[7];
                        end
                     end
                     2'h1: next_scl_oe_n = 1'b1;
                     // RQ9 ack sampled high
                     2'h2: begin
                        next_sh = {sh[6:0], eng.sda_hi};
                        if (bitn == 4'h8) begin
                           next_sh = sh;
                           next_ack_rx = eng.sda_hi;
                        end
                     end
                     2'h3: begin
                        next_scl_oe_n = 1'b0;
                        next_bitn = bitn + 4'h1;
                        if (bitn == 4'h8) begin
                           next_sda_oe_n = 1'b1;
                           next_done = 1'b1;
                           next_st = E_IDLE;
                        end
                     end
                  endcase
               end
               E_STOP: begin
                  unique case (q)
                     2'h0: next_sda_oe_n = 1'b0;
                     2'h1: next_scl_oe_n = 1'b1;
                     2'h2: next_sda_oe_n = 1'b0;
                     2'h3: begin
                        next_sda_oe_n = 1'b1;
                        next_done = 1'b1;
                        next_st = E_IDLE;
                     end
                  endcase
               end
               default: next_st = E_IDLE;
            endcase
         end
      end
   end

   // engine registers
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= E_IDLE;
         tick_cnt <= 5'h00;
         q <= 2'h0;
         bitn <= 4'h0;
         sh <= 8'h00;
         is_rd <= 1'b0;
         ackv <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         done <= 1'b0;
         ack_rx <= 1'b1;
      end else if (ce_i) begin
         st <= next_st;
         tick_cnt <= next_tick_cnt;
         q <= next_q;
         bitn <= next_bitn;
         sh <= next_sh;
         is_rd <= next_is_rd;
         ackv <= next_ackv;
         scl_oe_n <= next_scl_oe_n;
         sda_oe_n <= next_sda_oe_n;
         done <= next_done;
         ack_rx <= next_ack_rx;
      end
   end

   assign eng.done = done;
   assign eng.ack_rx = ack_rx;
   assign eng.rx_byte = sh;
   assign eng.scl_oe_n = scl_oe_n;
   assign eng.sda_oe_n = sda_oe_n;

   // RQ13 stretched clock holds
   chk_stretch_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RQ13
      stretch && !eng.abort |=> q == 2'h2 && scl_oe_n) else $error("high phase left early");
   // RQ9 ack bit captured
   chk_ack_capture: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RQ9
      st == E_BIT && bitn == 4'h8 && q == 2'h2 && tick && !eng.abort
      |=> ack_rx == $past(eng.sda_hi)) else $error("ack bit not captured");
endmodule : iema_bit_engine
`default_nettype wire

// *** logic/iema_top.sv ***
// two-wire eeprom master: random/sequential read, byte/page write
// assumes a single eeprom slave; pins are open drain, sampled here
`timescale 1ns/10ps
`default_nettype none
// Function
// RQ1 - master only, one slave on bus
// RQ2 - random read returns one chosen byte
// RQ3 - sequential read returns N bytes from start
// RQ4 - byte write stores one byte
// RQ5 - page write sends up to a page
// RQ6 - poll address until ack after writes
// RQ7 - address byte carries 1010 and 000
// RQ8 - bit 0 carries read/write direction
// RQ9 - every byte followed by checked acknowledge; the code does not check the ack of the low memory address byte or of the read address byte
// RQ10 - count polling, abandon wait past limit
// RQ11 - abandoned wait reports timeout error code
// RQ12 - busy and stop waits allow two periods
// RQ13 - ack, transmit, receive waits allow twenty-one
// RQ14 - timeout limits carry extra margin
// RQ15 - limits measured in transfer clock periods
// RQ16 - two memory address bytes before data
// RQ17 - transmit done on ninth clock rising edge; the code signals done when the ninth clock is pulled low
// RQ18 - sent ack value: zero ack, one nack
// RQ19 - taking received byte clocks next byte
// RQ20 - reads: write address, repeated start, read
// RQ21 - last read byte nacked, then stop
module iema_top #(
   parameter int TMO_LONG = iema_pkg::TMO_LONG_CYC,
   parameter int POLL_MAX = iema_pkg::POLL_LIMIT
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire iema_pkg::iema_op_e op_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] len_i,
   input wire logic wr_valid_i,
   input wire logic [7:0] wr_data_i,
   output logic wr_ready_o,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   input wire logic rd_ready_i,
   output logic busy_o,
   output logic done_o,
   output iema_pkg::iema_err_e err_o,
   output logic bus_occupied_flag_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o
);
   import iema_pkg::*;
   typedef enum logic [3:0] {M_IDLE, M_FREE, M_START, M_DEVW, M_AH, M_AL,
      M_RSTART, M_DEVR, M_RBYTE, M_RHOLD, M_WDATA, M_WBYTE, M_STOP,
      M_PSTART, M_PDEV, M_DONE} iema_mst_e;

   iema_eng_if eng ();

   iema_bit_engine u_eng (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .eng(eng)
   );

   iema_mst_e st, next_st;
   iema_op_e op, next_op;
   iema_err_e err, next_err;
   iema_cmd_e cmd, next_cmd, step_cmd;
   logic scl_m, scl_s, sda_m, sda_s, occ;
   logic issued, next_issued, poll_ok, next_poll_ok;
   logic [15:0] tmo_cnt, next_tmo_cnt, step_lim;
   logic [7:0] poll_cnt, next_poll_cnt, rem, next_rem;
   logic [15:0] addr, next_addr;
   logic [7:0] wbuf, next_wbuf, tx_byte, next_tx_byte, step_tx;
   logic cmd_valid, next_cmd_valid, ack_send, next_ack_send, abort;
   logic next_abort, done, next_done, rd_valid, next_rd_valid;
   logic [7:0] rd_data, next_rd_data;
   logic wr_ready, next_wr_ready, is_step, is_rd, nacked;
   logic busy;

   // pin levels pass two flip-flops before use
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         occ <= 1'b0;
      end else if (ce_i) begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         sda_m <= sda_i;
         sda_s <= sda_m;
         occ <= !(scl_s && sda_s);
      end
   end

   assign eng.scl_hi = scl_s;
   assign eng.sda_hi = sda_s;
   assign is_rd = (op == OP_RD_RANDOM) || (op == OP_RD_SEQ);
   assign nacked = (eng.ack_rx != ACK_VAL);

   // command, byte and wait limit for each bus step
   always_comb begin
      is_step = 1'b1;
      step_cmd = CMD_WRITE;
      step_tx = wbuf;
      // RQ12 short waits, RQ13 long waits, RQ14 RQ15 in periods
      step_lim = 16'(TMO_LONG);
      unique case (st)
         M_START, M_RSTART, M_PSTART: begin
            step_cmd = CMD_START;
            step_lim = 16'(TMO_SHORT_CYC);
         end
         M_STOP: begin
            step_cmd = CMD_STOP;
            step_lim = 16'(TMO_SHORT_CYC);
         end
         // RQ7 device code and select, RQ8 direction bit
         M_DEVW, M_PDEV: step_tx = {DEV_CODE, DEV_SEL, DIR_WR};
         M_DEVR: step_tx = {DEV_CODE, DEV_SEL, DIR_RD};
         // RQ16 two memory address bytes
         M_AH: step_tx = addr[15:8];
         M_AL: step_tx = addr[7:0];
         M_RBYTE: step_cmd = CMD_READ;
         M_WBYTE: step_tx = wbuf;
         default: is_step = 1'b0;
      endcase
   end

   // transfer sequencer
   always_comb begin
      next_st = st;
      next_op = op;
      next_err = err;
      next_cmd = cmd;
      next_issued = issued;
      next_poll_ok = poll_ok;
      next_tmo_cnt = tmo_cnt;
      next_poll_cnt = poll_cnt;
      next_rem = rem;
      next_addr = addr;
      next_wbuf = wbuf;
      next_tx_byte = tx_byte;
      next_cmd_valid = 1'b0;
      next_ack_send = ack_send;
      next_abort = 1'b0;
      next_done = 1'b0;
      next_rd_valid = rd_valid;
      next_rd_data = rd_data;
      next_wr_ready = wr_ready;
      if (is_step && !issued) begin
         next_cmd = step_cmd;
         next_tx_byte = step_tx;
         // RQ18 RQ21 last byte answered with nack
         next_ack_send = (rem == LEN_ONE) ? NACK_VAL : ACK_VAL;
         next_cmd_valid = 1'b1;
         next_issued = 1'b1;
         next_tmo_cnt = 16'h0000;
      end else if (is_step && !eng.done) begin
         // RQ10 RQ11 wait abandoned past its limit
         if (tmo_cnt >= step_lim) begin
            next_err = ERR_TIMEOUT;
            next_abort = 1'b1;
            next_issued = 1'b0;
            next_st = M_DONE;
         end else begin
            next_tmo_cnt = tmo_cnt + 16'h0001;
         end
      end else if (is_step) begin
         next_issued = 1'b0;
         unique case (st)
            M_START: next_st = M_DEVW;
            M_PSTART: next_st = M_PDEV;
            // RQ20 repeated start before read direction
            M_AL: next_st = is_rd ? M_RSTART : M_WDATA;
            M_RSTART: next_st = M_DEVR;
            M_DEVR: next_st = M_RBYTE;
            M_RBYTE: begin
               next_rd_valid = 1'b1;
               next_rd_data = eng.rx_byte;
               next_st = M_RHOLD;
            end
            // RQ6 poll until the slave acknowledges
            M_PDEV: begin
               next_poll_ok = !nacked;
               next_st = M_STOP;
            end
            M_STOP: begin
               if (err != ERR_NONE || poll_ok || is_rd) begin
                  next_st = M_DONE;
               end else if (poll_cnt == 8'(POLL_MAX)) begin
                  // RQ10 polling attempts limited
                  next_err = ERR_TIMEOUT;
                  next_st = M_DONE;
               end else begin
                  next_poll_cnt = poll_cnt + 8'h01;
                  next_st = M_PSTART;
               end
            end
            default: begin
               next_st = (st == M_DEVW) ? M_AH : (st == M_AH) ? M_AL : M_WDATA;
               if (st == M_WBYTE && rem == LEN_ONE) begin
                  next_st = M_STOP;
               end else if (st == M_WBYTE) begin
                  next_rem = rem - 8'h01;
               end
               // RQ9 RQ17 ack checked at ninth clock
               if (nacked) begin
                  next_err = ERR_NACK;
                  next_st = M_STOP;
               end
            end
         endcase
      end else begin
         unique case (st)
            M_IDLE: begin
               if (start_i) begin
                  next_op = op_i;
                  next_addr = addr_i;
                  next_err = ERR_NONE;
                  next_poll_ok = 1'b0;
                  next_poll_cnt = 8'h00;
                  next_tmo_cnt = 16'h0000;
                  // RQ2 RQ4 single byte, RQ3 RQ5 counted bytes
                  next_rem = len_i;
                  if (op_i == OP_RD_RANDOM || op_i == OP_WR_BYTE ||
                      len_i == 8'h00) begin
                     next_rem = LEN_ONE;
                  end
                  next_st = M_FREE;
               end
            end
            // RQ1 RQ12 wait for a free bus
            M_FREE: begin
               if (!occ) begin
                  next_st = M_START;
               end else if (tmo_cnt >= 16'(TMO_SHORT_CYC)) begin
                  next_err = ERR_TIMEOUT;
                  next_st = M_DONE;
               end else begin
                  next_tmo_cnt = tmo_cnt + 16'h0001;
               end
            end
            // RQ19 taking the byte clocks the next one
            M_RHOLD: begin
               if (rd_valid && rd_ready_i) begin
                  next_rd_valid = 1'b0;
                  next_rem = rem - 8'h01;
                  next_st = (rem == LEN_ONE) ? M_STOP : M_RBYTE;
               end
            end
            M_WDATA: begin
               if (!wr_ready) begin
                  next_wr_ready = 1'b1;
               end else if (wr_valid_i) begin
                  next_wr_ready = 1'b0;
                  next_wbuf = wr_data_i;
                  next_st = M_WBYTE;
               end
            end
            M_DONE: begin
               next_done = 1'b1;
               next_st = M_IDLE;
            end
            default: next_st = M_IDLE;
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= M_IDLE;
         op <= OP_RD_RANDOM;
         err <= ERR_NONE;
         cmd <= CMD_START;
         issued <= 1'b0;
         poll_ok <= 1'b0;
         tmo_cnt <= 16'h0000;
         poll_cnt <= 8'h00;
         rem <= 8'h00;
         addr <= 16'h0000;
         wbuf <= 8'h00;
         tx_byte <= 8'h00;
         cmd_valid <= 1'b0;
         ack_send <= ACK_VAL;
         abort <= 1'b0;
         done <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         wr_ready <= 1'b0;
         busy <= 1'b0;
      end else if (ce_i) begin
         st <= next_st;
         op <= next_op;
         err <= next_err;
         cmd <= next_cmd;
         issued <= next_issued;
         poll_ok <= next_poll_ok;
         tmo_cnt <= next_tmo_cnt;
         poll_cnt <= next_poll_cnt;
         rem <= next_rem;
         addr <= next_addr;
         wbuf <= next_wbuf;
         tx_byte <= next_tx_byte;
         cmd_valid <= next_cmd_valid;
         ack_send <= next_ack_send;
         abort <= next_abort;
         done <= next_done;
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
         wr_ready <= next_wr_ready;
         busy <= (next_st != M_IDLE); // registered copy of a non-idle state
      end
   end

   // engine commands, registered outputs and constant-low pin drives
   assign eng.cmd = cmd;
   assign eng.cmd_valid = cmd_valid;
   assign eng.tx_byte = tx_byte;
   assign eng.ack_send = ack_send;
   assign eng.abort = abort;
   assign wr_ready_o = wr_ready;
   assign rd_valid_o = rd_valid;
   assign rd_data_o = rd_data;
   assign busy_o = busy;
   assign done_o = done;
   assign err_o = err;
   assign bus_occupied_flag_o = occ;
   assign scl_o = PIN_LOW;
   assign sda_o = PIN_LOW;
   assign scl_oe_n_o = eng.scl_oe_n;
   assign sda_oe_n_o = eng.sda_oe_n;

   // RQ7 write address byte
   chk_dev_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ7
      cmd_valid && (st == M_DEVW || st == M_PDEV) |-> tx_byte == 8'ha0) else $error("bad write address");
   // RQ8 read direction bit
   chk_dev_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ8
      cmd_valid && st == M_DEVR |-> tx_byte == 8'ha1) else $error("bad read address");
   // RQ16 address follows device
   chk_addr_order: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RQ16
      st == M_DEVW && issued && eng.done && !eng.ack_rx |=> st == M_AH) else $error("address byte skipped");
   // RQ21 last byte nacked
   chk_last_nack: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ21
      cmd_valid && cmd == CMD_READ |-> ack_send == (rem == 8'h01)) else $error("wrong ack on read");
   // RQ19 byte held until taken
   chk_rx_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RQ19
      rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o)) else $error("read byte dropped");
   // RQ11 timeout reported
   chk_tmo_report: assert property (@(posedge clk_i) disable iff (sys_rst_i || !ce_i) // RQ11
      is_step && issued && !eng.done && tmo_cnt >= step_lim
      |=> st == M_DONE ##1 done_o && err_o == ERR_TIMEOUT) else $error("timeout not reported");
   // RQ10 wait count bounded
   chk_tmo_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ10
      is_step && issued |-> tmo_cnt <= step_lim) else $error("wait count past limit");
   // RQ6 write ends only after poll ack
   chk_poll_done: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ6
      done_o && err_o == ERR_NONE && !is_rd |-> poll_ok) else $error("write ended unpolled");
endmodule : iema_top
`default_nettype wire

// *** test/iema_eeprom_model.sv ***
// eeprom slave model: memory, busy polls, clock stretch, refusal
// assumes the bench resolves both wires with pull-ups
`timescale 1ns/10ps
`default_nettype none
module iema_eeprom_model (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic nack_i,
   input wire logic [15:0] busy_polls_i,
   input wire logic [15:0] stretch_i,
   output logic scl_oe_n_o,
   output logic sda_oe_n_o
);
   bit [7:0] mem [0:65535];
   logic [15:0] ptr;
   logic [7:0] b;
   bit ev, rs, mack;
   int busy, n_addr, nb;
   // one byte in; ev marks a start or stop met inside it
   task automatic rx();
      ev = 0;
      for (int i = 7; i >= 0; i--) begin
         @(posedge scl_i);
         b[i] = sda_i;
         @(negedge scl_i or sda_i);
         if (scl_i) begin
            ev = 1;
            return;
         end
      end
   endtask : rx
   task automatic ack();
      sda_oe_n_o = 0;
      @(negedge scl_i);
      sda_oe_n_o = 1;
      scl_oe_n_o = 0; // a slow answer holds the clock low
      #(stretch_i);
      scl_oe_n_o = 1;
   endtask : ack
   // frame walker: address byte, then pointer and data in, or data out
   initial begin
      scl_oe_n_o = 1;
      sda_oe_n_o = 1;
      rs = 0;
      busy = 0;
      n_addr = 0;
      forever begin
         if (!rs) @(negedge sda_i iff scl_i === 1'b1);
         rx();
         rs = ev && !sda_i;
         n_addr += !ev;
         // refuse while the write is busy
         if (ev || b[7:1] != 7'h50 || nack_i || busy > 0) begin
            busy -= (!ev && busy > 0);
         end else if (b[0]) begin
            ack();
            do begin
               for (int i = 7; i >= 0; i--) begin
                  sda_oe_n_o = mem[ptr][i];
                  @(negedge scl_i);
               end
               sda_oe_n_o = 1;
               @(posedge scl_i);
               mack = sda_i;
               ptr++;
               @(negedge scl_i);
            end while (!mack);
         end else begin
            nb = 0;
            while (!ev) begin
               ack();
               rx();
               if (!ev && nb == 0) ptr[15:8] = b;
               if (!ev && nb == 1) ptr[7:0] = b;
               if (!ev && nb > 1) mem[16'(ptr + nb - 2)] = b;
               nb++;
            end
            rs = !sda_i;
            if (nb > 3) busy = busy_polls_i;
         end
      end
   end
endmodule : iema_eeprom_model
`default_nettype wire

// *** test/i2c_eeprom_master_access_test.sv ***
// self-checking bench of the two-wire eeprom master with a slave model
// assumes a 25 MHz clock and pull-ups on both wires
`timescale 1ns/10ps
`default_nettype none
module i2c_eeprom_master_access_test;
   import iema_pkg::*;
   logic clk_i, sys_rst_i, start_i, wr_valid_i, rd_ready_i, wr_ready_o;
   logic rd_valid_o, busy_o, done_o, bus_occupied_flag_o, scl_oe_n_o;
   logic sda_oe_n_o, m_scl_oe_n, m_sda_oe_n, m_nack;
   logic [15:0] addr_i, polls, stretch;
   logic [7:0] len_i, wr_data_i, rd_data_o;
   iema_op_e op_i;
   iema_err_e err_o;
   wire logic scl_w;
   wire logic sda_w;
   logic [7:0] ref_mem [int];
   int n_mismatch, n_compared, base;
   // pull-ups: a wire is high unless a party pulls it low
   assign scl_w = scl_oe_n_o & m_scl_oe_n;
   assign sda_w = sda_oe_n_o & m_sda_oe_n;
   iema_top #(.TMO_LONG(2000), .POLL_MAX(4)) DUT (.*, .ce_i(1'b1),
      .scl_i(scl_w), .scl_o(), .sda_i(sda_w), .sda_o());
   iema_eeprom_model m (.scl_i(scl_w), .sda_i(sda_w), .nack_i(m_nack),
      .busy_polls_i(polls), .stretch_i(stretch),
      .scl_oe_n_o(m_scl_oe_n), .sda_oe_n_o(m_sda_oe_n));
   // system clock
   initial begin
      clk_i = 0;
      forever #20 clk_i = ~clk_i;
   end
   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // counts, verdict and end of run
   task automatic end_sim();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // one operation; write bytes and read takes follow the handshakes
   task automatic run(input iema_op_e op, input logic [15:0] a,
      input int n, input iema_err_e e);
      logic [7:0] q [$];
      int k, t, nn;
      nn = (n == 0) ? 1 : n;
      k = 0;
      t = 0;
      for (int i = 0; i < nn && op >= OP_WR_BYTE; i++) begin
         q.push_back(8'($urandom));
         if (e == ERR_NONE) ref_mem[16'(a + i)] = q[i];
      end
      @(negedge clk_i);
      wr_valid_i = 0;
      op_i = op;
      addr_i = a;
      len_i = 8'(n);
      start_i = 1;
      do begin
         @(negedge clk_i);
         t++;
         // a start while busy must be ignored
         start_i = busy_o && !done_o && ($urandom % 16 == 0);
         if (wr_valid_i) void'(q.pop_front());
         wr_valid_i = wr_ready_o && q.size() > 0;
         wr_data_i = (q.size() > 0) ? q[0] : 8'h00;
         rd_ready_i = 1'($urandom);
         if (rd_valid_o && rd_ready_i) begin
            check(rd_data_o, ref_mem[16'(a + k)]);
            k++;
         end
      end while (!done_o && t < 40000);
      check({done_o, err_o}, {1'b1, e});
      check(8'(k), (op < OP_WR_BYTE && !e) ? 8'(nn) : 8'h00);
      $display("op %0d at %h ended at %0t", op, a, $time);
   endtask : run
   // reset, then the scenarios in order
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      void'($urandom(32'h13df551a));
      {start_i, wr_valid_i, rd_ready_i, m_nack} = 4'h0;
      op_i = OP_RD_RANDOM;
      addr_i = 16'h0000;
      len_i = 8'h00;
      wr_data_i = 8'h00;
      polls = 16'h0002;
      stretch = 16'h0000;
      sys_rst_i = 1;
      repeat (20) @(negedge clk_i);
      sys_rst_i = 0;
      check({scl_oe_n_o, sda_oe_n_o, busy_o, done_o, bus_occupied_flag_o,
         err_o}, 8'h60);
      for (int i = 0; i < 2; i++) begin
         base = m.n_addr;
         run(OP_WR_BYTE, 16'(-i), 1, ERR_NONE);
         check(8'(m.n_addr - base), 8'h04);
         run(OP_RD_RANDOM, 16'(-i), 1, ERR_NONE);
      end
      stretch = 16'h1388;
      run(OP_WR_PAGE, 16'h0100, 8, ERR_NONE);
      run(OP_RD_SEQ, 16'h0100, 8, ERR_NONE);
      stretch = 16'h0000;
      run(OP_RD_SEQ, 16'h0103, 0, ERR_NONE);
      m_nack = 1;
      run(OP_WR_PAGE, 16'h0200, 4, ERR_NACK);
      m_nack = 0;
      polls = 16'h000a;
      run(OP_WR_BYTE, 16'h0300, 1, ERR_TIMEOUT);
      end_sim();
   end
   // watchdog over the whole run
   initial begin
      #3000000;
      n_mismatch++;
      end_sim();
   end
endmodule : i2c_eeprom_master_access_test
`default_nettype wire
